// ### rtl/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register byte addresses
`define WDT_ADDR_KEY      32'hB7E0_0000
`define WDT_ADDR_CFG      32'hB7E0_0004
`define WDT_ADDR_COUNT    32'hB7E0_0008
`define WDT_ADDR_STAT     32'hB7E0_0014

// Service key and unlock values
`define WDT_KEY_START     8'h3C
`define WDT_KEY_FIRST     8'hC3
`define WDT_CFG_UNLOCK    8'h5A

// Configuration field positions
`define WDT_CFG_CLK_LO    0
`define WDT_CFG_CLK_HI    1
`define WDT_CFG_ITM       3
`define WDT_CFG_INTERVAL_RUN      4
`define WDT_CFG_OFINT     6
`define WDT_CFG_HALT      7
`define WDT_CFG_RESET     8'h00

// Status field positions
`define WDT_STAT_RSTSRC   0
`define WDT_STAT_WDIRQ    4
`define WDT_STAT_IVIRQ    5

// Divider select codes
`define WDT_DIV_1         2'h0
`define WDT_DIV_4         2'h1
`define WDT_DIV_16        2'h2
`define WDT_DIV_64        2'h3

// Prescale masks for each divide ratio
`define WDT_MASK_1        6'h00
`define WDT_MASK_4        6'h03
`define WDT_MASK_16       6'h0F
`define WDT_MASK_64       6'h3F

// Reset pulse length in bus clocks
`define WDT_RST_CYCLES    5'h10

`endif

// ### rtl/wdt_pkg.sv
package wdt_pkg;

    // Configuration register fields, low byte
    typedef struct packed {
        logic       halt;
        logic       ofint;
        logic       rsv5;
        logic       interval_run;
        logic       interval_mode_select;
        logic       rsv2;
        logic [1:0] clk_sel;
    } wdt_cfg_s;

    // Service key sequence states, Gray along the path
    typedef enum logic [1:0] {
        KEY_STOPPED = 2'h0,
        KEY_ARMED   = 2'h1,
        KEY_PAIR    = 2'h3
    } wdt_key_e;

endpackage

// ### rtl/wdt_prescaler.sv
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_prescaler (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       src_tick,
    input  wire logic       clr,
    input  wire logic [1:0] sel,
    // Divided tick
    output logic            cnt_tick
);

    logic [5:0] pre_q;  // Source edge counter

    // Mask of low prescale bits for a divide code
    function automatic logic [5:0] div_mask(input logic [1:0] s);
        case (s)
            `WDT_DIV_1:  div_mask = `WDT_MASK_1;
            `WDT_DIV_4:  div_mask = `WDT_MASK_4;
            `WDT_DIV_16: div_mask = `WDT_MASK_16;
            default:     div_mask = `WDT_MASK_64;
        endcase
    endfunction

    // Tick when all masked bits are ones on a source edge
    always_comb begin
        cnt_tick = src_tick && ((pre_q & div_mask(sel)) == div_mask(sel));
    end

    // Free counter of source edges; cleared with the main counter
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            pre_q <= 6'h00;
        end else if (src_tick) begin
            pre_q <= pre_q + 6'h01;
        end
    end

endmodule

// ### rtl/wdt_top.sv
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_top #(
    parameter int CNT_W = 16  // Counter width
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // Count source clock, sampled as a level
    input  wire logic        COUNT_SRC_CLK,
    // Register port
    input  wire logic [31:0] BUS_ADDR,
    input  wire logic [31:0] BUS_WDATA,
    input  wire logic        BUS_WR,
    input  wire logic        BUS_RD,
    output logic      [31:0] BUS_RDATA,
    // System outputs
    output logic             IRQ,
    output logic             WDT_RESET_OUT
);

    // Bus decode strobes
    logic                  wr_key;     // Write to service key
    logic                  wr_cfg;     // Write to configuration
    logic                  wr_stat;    // Write to status
    logic [7:0]            wbyte;      // Low write byte

    // Configuration state
    wdt_pkg::wdt_cfg_s     cfg_q;      // Live configuration
    logic                  unlock_q;   // Unlock value seen
    wdt_pkg::wdt_cfg_s     cfg_new;    // Masked write value

    // Service key sequence
    wdt_pkg::wdt_key_e     key_q;      // Sequence state
    wdt_pkg::wdt_key_e     key_d;      // Next sequence state
    logic                  key_clr;    // Counter clear request

    // Count path
    logic                  src_q;      // Previous source level
    logic                  src_tick;   // Source rising edge
    logic                  cnt_tick;   // Divided count tick
    logic                  running;    // Counter may advance
    logic [CNT_W-1:0]      count_q;    // Timer counter
    logic                  ovf;        // Overflow this cycle

    // Overflow consequences
    logic                  ovf_rst;    // Overflow wants reset
    logic                  ovf_wdirq;  // Overflow sets watchdog flag
    logic                  ovf_ivirq;  // Overflow sets interval flag

    // Status and reset pulse
    logic                  wdirq_q;    // Watchdog interrupt flag
    logic                  ivirq_q;    // Interval interrupt flag
    logic                  rstsrc_q;   // Last reset came from here
    logic [4:0]            rst_cnt_q;  // Reset pulse cycles left

    // Address decode; only low byte of data is meaningful
    always_comb begin
        wr_key  = BUS_WR && (BUS_ADDR == `WDT_ADDR_KEY);
        wr_cfg  = BUS_WR && (BUS_ADDR == `WDT_ADDR_CFG);
        wr_stat = BUS_WR && (BUS_ADDR == `WDT_ADDR_STAT);
        wbyte   = BUS_WDATA[7:0];
    end

    // Drop reserved bits from a configuration write
    always_comb begin
        cfg_new      = wdt_pkg::wdt_cfg_s'(wbyte);
        cfg_new.rsv5 = 1'b0;
        cfg_new.rsv2 = 1'b0;
    end

    // Unlock flag: armed by the unlock value, spent by next write
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            unlock_q <= 1'b0;
        end else if (wr_cfg) begin
            // Unlock value only arms while locked; written while unlocked it is stored
            unlock_q <= !unlock_q && (wbyte == `WDT_CFG_UNLOCK);
        end
    end

    // Configuration register; a stray locked write is dropped
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_q <= wdt_pkg::wdt_cfg_s'(`WDT_CFG_RESET);
        end else if (wr_cfg && unlock_q) begin
            cfg_q <= cfg_new;
        end
    end

    // Service key sequence, decided by mode
    always_comb begin
        key_d   = key_q;
        key_clr = 1'b0;
        if (wr_key) begin
            case (key_q)
                wdt_pkg::KEY_STOPPED: begin
                    // Only the start value wakes the counter
                    if (wbyte == `WDT_KEY_START) begin
                        key_d   = wdt_pkg::KEY_ARMED;
                        key_clr = 1'b1;
                    end
                end
                wdt_pkg::KEY_ARMED: begin
                    if (cfg_q.interval_mode_select) begin
                        // Interval mode clears on a single start value
                        key_clr = (wbyte == `WDT_KEY_START);
                    end else if (wbyte == `WDT_KEY_FIRST) begin
                        key_d = wdt_pkg::KEY_PAIR;
                    end
                end
                wdt_pkg::KEY_PAIR: begin
                    if (wbyte == `WDT_KEY_START) begin
                        key_d   = wdt_pkg::KEY_ARMED;
                        key_clr = 1'b1;
                    end
                    // Any other value leaves the half pair waiting
                end
                default: begin
                    key_d = wdt_pkg::KEY_STOPPED;
                end
            endcase
        end
        // Unexpected values fall through untouched
    end

    // Key sequence state
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            key_q <= wdt_pkg::KEY_STOPPED;
        end else begin
            key_q <= key_d;
        end
    end

    // Source clock edge; input taken as synchronous to CLK
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            src_q <= 1'b0;
        end else begin
            src_q <= COUNT_SRC_CLK;
        end
    end

    // Rising edge of the count source
    always_comb begin
        src_tick = COUNT_SRC_CLK && !src_q;
    end

    // Divider shares the clear so a serviced count restarts cleanly
    wdt_prescaler u_prescaler (
        .clk      (CLK),
        .rst      (SYS_RST),
        .src_tick (src_tick),
        .clr      (key_clr),
        .sel      (cfg_q.clk_sel),
        .cnt_tick (cnt_tick)
    );

    // Run gate: started, not halted, interval needs its run bit
    always_comb begin
        running = (key_q != wdt_pkg::KEY_STOPPED)
                  && !cfg_q.halt
                  && (!cfg_q.interval_mode_select || cfg_q.interval_run);
    end

    // Overflow at the wrap from all ones
    always_comb begin
        ovf = running && cnt_tick && (&count_q);
    end

    // Up-counter; clear has priority over a tick
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            count_q <= '0;
        end else if (key_clr) begin
            count_q <= '0;
        end else if (running && cnt_tick) begin
            count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Route an overflow by mode and action bit
    // Limitation: a service write that lands in the wrap cycle clears the
    // count but does not cancel that overflow; software must service early
    always_comb begin
        ovf_ivirq = ovf && cfg_q.interval_mode_select;
        ovf_rst   = ovf && !cfg_q.interval_mode_select && cfg_q.ofint;
        ovf_wdirq = ovf && !cfg_q.interval_mode_select && !cfg_q.ofint;
    end

    // Watchdog flag; a new event beats a same-cycle clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wdirq_q <= 1'b0;
        end else if (ovf_wdirq) begin
            wdirq_q <= 1'b1;
        end else if (wr_stat && BUS_WDATA[`WDT_STAT_WDIRQ]) begin
            wdirq_q <= 1'b0;
        end
    end

    // Interval flag, same handling as the watchdog flag
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ivirq_q <= 1'b0;
        end else if (ovf_ivirq) begin
            ivirq_q <= 1'b1;
        end else if (wr_stat && BUS_WDATA[`WDT_STAT_IVIRQ]) begin
            ivirq_q <= 1'b0;
        end
    end

    // Reset source flag; only the system reset clears it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rstsrc_q <= 1'b0;
        end else if (ovf_rst) begin
            rstsrc_q <= 1'b1;
        end
    end

    // Reset pulse length counter; a repeat overflow restarts it
    // The pulse only leaves the block; nothing here is reset by it, so the
    // source flag survives for software to read after the restart
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rst_cnt_q <= 5'h00;
        end else if (ovf_rst) begin
            rst_cnt_q <= `WDT_RST_CYCLES;
        end else if (rst_cnt_q != 5'h00) begin
            rst_cnt_q <= rst_cnt_q - 5'h01;
        end
    end

    // Reset output registered; high while cycles remain
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            WDT_RESET_OUT <= 1'b0;
        end else begin
            WDT_RESET_OUT <= ovf_rst || (rst_cnt_q > 5'h01);
        end
    end

    // Interrupt line follows either sticky flag, registered
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= wdirq_q || ivirq_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    // Zero outside that cycle so a stale value is never mistaken for data
    always_ff @(posedge CLK) begin
        if (SYS_RST || !BUS_RD) begin
            BUS_RDATA <= 32'h0000_0000;
        end else begin
            case (BUS_ADDR)
                `WDT_ADDR_KEY: begin
                    BUS_RDATA <= 32'h0000_0000;
                end
                `WDT_ADDR_CFG: begin
                    BUS_RDATA <= {24'h00_0000, cfg_q};
                end
                `WDT_ADDR_COUNT: begin
                    BUS_RDATA <= 32'(count_q);
                end
                `WDT_ADDR_STAT: begin
                    BUS_RDATA <= 32'h0000_0000
                        | (32'(rstsrc_q) << `WDT_STAT_RSTSRC)
                        | (32'(wdirq_q)  << `WDT_STAT_WDIRQ)
                        | (32'(ivirq_q)  << `WDT_STAT_IVIRQ);
                end
                default: begin
                    // Unmapped addresses read zero
                    BUS_RDATA <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

// ### testbench/wdt_top_properties.sv
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_top_properties (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        SYS_RST,
    // Watched ports
    input wire logic        COUNT_SRC_CLK,
    input wire logic [31:0] BUS_ADDR,
    input wire logic [31:0] BUS_WDATA,
    input wire logic        BUS_WR,
    input wire logic        BUS_RD,
    input wire logic [31:0] BUS_RDATA,
    input wire logic        IRQ,
    input wire logic        WDT_RESET_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    logic [4:0] run_q;  // Pulse cycles so far
    logic [7:0] cfg_q;  // Expected config
    logic       arm_q;  // Unlock seen
    wire        wr_cfg = BUS_WR && BUS_ADDR == `WDT_ADDR_CFG;
    wire        rd_stat = BUS_RD && BUS_ADDR == `WDT_ADDR_STAT;

    // Config mirror, reserved bits masked
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_q <= 8'h00;
            arm_q <= 1'b0;
        end else if (wr_cfg) begin
            if (arm_q) begin
                cfg_q <= BUS_WDATA[7:0] & 8'hDB;
            end
            arm_q <= !arm_q && BUS_WDATA[7:0] == `WDT_CFG_UNLOCK;
        end
    end

    // Length of the reset pulse
    always_ff @(posedge CLK) begin
        if (SYS_RST || !WDT_RESET_OUT) begin
            run_q <= 5'h00;
        end else begin
            run_q <= run_q + 5'h01;
        end
    end

    AST_CFG_READ: assert property (BUS_RD && BUS_ADDR == `WDT_ADDR_CFG
        |=> BUS_RDATA == {24'h0, $past(cfg_q)}) else $error("config readback wrong");
    AST_KEY_READ: assert property (BUS_RD && BUS_ADDR == `WDT_ADDR_KEY
        |=> BUS_RDATA == 32'h0) else $error("key register read not zero");
    AST_STAT_RSV: assert property (rd_stat
        |=> BUS_RDATA[31:6] == 26'h0 && BUS_RDATA[3:1] == 3'h0) else $error("status spare bits");
    AST_RST_MAX: assert property (WDT_RESET_OUT |-> run_q < 5'h10)
        else $error("reset pulse too long");
    AST_RST_LEN: assert property ($fell(WDT_RESET_OUT) && !$past(SYS_RST)
        |-> run_q == 5'h10) else $error("reset pulse too short");
    AST_IRQ_CLEAR: assert property (BUS_WR && BUS_ADDR == `WDT_ADDR_STAT
        && BUS_WDATA[5:4] == 2'h3 |-> ##[1:20] !IRQ) else $error("interrupt not cleared");
    AST_RST_STATUS: assert property (rd_stat && WDT_RESET_OUT |=> BUS_RDATA[0])
        else $error("reset source flag missing");
    AST_RST_MODE: assert property ($rose(WDT_RESET_OUT) |-> cfg_q[6] && !cfg_q[3])
        else $error("reset in wrong mode");

    // Main scenarios
    COV_CFG: cover property (wr_cfg && arm_q);
    COV_START: cover property (BUS_WR && BUS_ADDR == `WDT_ADDR_KEY);
    COV_STAT: cover property (BUS_WR && BUS_ADDR == `WDT_ADDR_STAT);
endmodule

bind wdt_top wdt_top_properties u_props (.CLK(CLK), .SYS_RST(SYS_RST),
    .COUNT_SRC_CLK(COUNT_SRC_CLK), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
    .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .IRQ(IRQ),
    .WDT_RESET_OUT(WDT_RESET_OUT));

// ### testbench/wdt_top_tb.sv
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_top_tb;
    logic        clk = 1'b0;   // Bus clock
    logic        rst = 1'b1;   // Reset
    logic        src = 1'b0;   // Count source
    logic [1:0]  sdiv = 2'h0;  // Source divider
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        irq;
    logic        rst_out;
    int          fails = 0;
    int          total_checks = 0;
    logic [31:0] a;            // Reads
    logic [31:0] b;
    // Short counter so an overflow fits in the run; rate windows stay below a wrap
    localparam int TB_CNT_W = 10;

    always #20 clk = ~clk;

    // Source edge every fourth bus clock, below the sampling limit
    always @(posedge clk) begin
        sdiv <= sdiv + 2'h1;
        src  <= sdiv[1];
    end

    wdt_top #(.CNT_W(TB_CNT_W)) u_dut (.CLK(clk), .SYS_RST(rst), .COUNT_SRC_CLK(src),
        .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata),
        .IRQ(irq), .WDT_RESET_OUT(rst_out));

    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr_reg(logic [31:0] ad, logic [31:0] d);
        @(posedge clk);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd_reg(logic [31:0] ad, output logic [31:0] d);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Unlock, then store
    task automatic set_cfg(logic [7:0] v);
        wr_reg(`WDT_ADDR_CFG, 32'h5A);
        wr_reg(`WDT_ADDR_CFG, {24'h0, v});
    endtask

    // Advance over cyc+2 edges; one count of slack for phase, none when stopped
    task automatic rate(string n, int cyc, int exp);
        int d;
        int t;
        rd_reg(`WDT_ADDR_COUNT, a);
        repeat (cyc) @(posedge clk);
        rd_reg(`WDT_ADDR_COUNT, b);
        d = (int'(b) - int'(a)) & ((1 << TB_CNT_W) - 1);
        t = (exp == 0) ? 0 : 1;
        chk(n, {31'h0, d >= exp - t && d <= exp + t}, 32'h1);
    endtask

    task automatic t_reset;
        rd_reg(`WDT_ADDR_CFG, a);
        chk("cfg reset", a, 32'h0);
        rd_reg(`WDT_ADDR_KEY, a);
        chk("key read", a, 32'h0);
        rate("idle count", 200, 0);
        $display("t_reset done");
    endtask

    task automatic t_lock;
        wr_reg(`WDT_ADDR_CFG, 32'h8B);
        rd_reg(`WDT_ADDR_CFG, a);
        chk("locked cfg", a, 32'h0);
        set_cfg(8'hFF);
        rd_reg(`WDT_ADDR_CFG, a);
        chk("cfg spare bits", a, 32'hDB);
        set_cfg(8'h18);
        rate("no start key", 200, 0);
        $display("t_lock done");
    endtask

    // Start once, then every divide ratio
    task automatic t_rates;
        set_cfg(8'h00);
        wr_reg(`WDT_ADDR_KEY, 32'h3C);
        for (int s = 0; s < 4; s++) begin
            set_cfg(8'(s));
            rate("divide ratio", 1022, 256 >> (2 * s));
        end
        $display("t_rates done");
    endtask

    task automatic t_clear;
        set_cfg(8'h00);
        rd_reg(`WDT_ADDR_COUNT, a);
        wr_reg(`WDT_ADDR_KEY, 32'h3C);
        rd_reg(`WDT_ADDR_COUNT, b);
        chk("lone key ignored", {31'h0, b > a}, 32'h1);
        wr_reg(`WDT_ADDR_KEY, 32'hC3);
        wr_reg(`WDT_ADDR_KEY, 32'h3C);
        rd_reg(`WDT_ADDR_COUNT, b);
        chk("pair clears", {31'h0, b < 32'h4}, 32'h1);
        $display("t_clear done");
    endtask

    task automatic t_halt;
        set_cfg(8'h80);
        rate("halted", 100, 0);
        set_cfg(8'h08);
        rate("interval stopped", 100, 0);
        set_cfg(8'h18);
        rate("interval run", 1022, 256);
        wr_reg(`WDT_ADDR_KEY, 32'h3C);
        rd_reg(`WDT_ADDR_COUNT, b);
        chk("interval clear", {31'h0, b < 32'h4}, 32'h1);
        $display("t_halt done");
    endtask

    // Overflow in each mode, each from a freshly serviced count
    task automatic t_ovf;
        int n;
        set_cfg(8'h00);
        wr_reg(`WDT_ADDR_KEY, 32'hC3);
        wr_reg(`WDT_ADDR_KEY, 32'h3C);
        @(negedge clk);
        for (n = 0; n < 5000 && !irq; n++) @(negedge clk);
        chk("watchdog irq", {31'h0, irq}, 32'h1);
        rd_reg(`WDT_ADDR_COUNT, b);
        chk("wrapped to zero", {31'h0, b < 32'h4}, 32'h1);
        rd_reg(`WDT_ADDR_STAT, a);
        chk("watchdog flag", a, 32'h10);
        chk("no reset on irq action", {31'h0, rst_out}, 32'h0);
        wr_reg(`WDT_ADDR_STAT, 32'h10);
        repeat (20) @(negedge clk);
        chk("watchdog irq cleared", {31'h0, irq}, 32'h0);
        set_cfg(8'h18);
        wr_reg(`WDT_ADDR_KEY, 32'h3C);
        @(negedge clk);
        for (n = 0; n < 5000 && !irq; n++) @(negedge clk);
        chk("interval irq", {31'h0, irq}, 32'h1);
        rd_reg(`WDT_ADDR_STAT, a);
        chk("interval flag", a, 32'h20);
        chk("no reset in interval", {31'h0, rst_out}, 32'h0);
        wr_reg(`WDT_ADDR_STAT, 32'h20);
        repeat (20) @(negedge clk);
        chk("interval irq cleared", {31'h0, irq}, 32'h0);
        set_cfg(8'h40);
        wr_reg(`WDT_ADDR_KEY, 32'hC3);
        wr_reg(`WDT_ADDR_KEY, 32'h3C);
        @(negedge clk);
        for (n = 0; n < 5000 && !rst_out; n++) @(negedge clk);
        chk("reset issued", {31'h0, rst_out}, 32'h1);
        n = 0;
        while (rst_out && n < 40) begin
            n++;
            @(negedge clk);
        end
        chk("reset pulse length", n, 32'd16);
        chk("no irq on reset action", {31'h0, irq}, 32'h0);
        rd_reg(`WDT_ADDR_STAT, a);
        chk("reset source", a, 32'h1);
        $display("t_ovf done");
    endtask

    // Flags clear by writing one; a mid-run reset clears the rest
    task automatic t_stat;
        wr_reg(`WDT_ADDR_STAT, 32'h31);
        repeat (20) @(posedge clk);
        rd_reg(`WDT_ADDR_STAT, a);
        chk("status clear", a, 32'h1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`WDT_ADDR_STAT, a);
        chk("status after reset", a, 32'h0);
        rd_reg(`WDT_ADDR_CFG, a);
        chk("cfg after reset", a, 32'h0);
        rate("stopped after reset", 100, 0);
        chk("irq low", {31'h0, irq}, 32'h0);
        chk("reset low", {31'h0, rst_out}, 32'h0);
        $display("t_stat done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_lock;
        t_rates;
        t_clear;
        t_halt;
        t_ovf;
        t_stat;
        final_report;
    end

    // Tests need about twenty thousand cycles, three overflows included
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        final_report;
    end
endmodule
